// [rsq_pkg.sv]
// Constants for the rail enable sequencing block: register offsets, field
// positions, reset values, pin-select codes and delay timing.
// Assumes a 20 MHz system clock and byte-wide configuration registers.
package rsq_pkg;

   // ==========================================================================
   // Clock and delay timing
   // ==========================================================================
   localparam int          RSQ_CLK_HZ      = 20_000_000;
   localparam int          RSQ_MS_PER_S    = 1000;
   localparam int          RSQ_CYC_PER_MS  = RSQ_CLK_HZ / RSQ_MS_PER_S;
   localparam int          RSQ_TOL_PCT     = 10;          // Allowed delay deviation
   localparam int          RSQ_MS_W        = 7;           // Holds up to 127 ms; the longest delay code is 64 ms

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [7:0]  RSQ_OFS_LDO3_DLY   = 8'h21;
   localparam logic [7:0]  RSQ_OFS_SW1_MASK_A = 8'h22;
   localparam logic [7:0]  RSQ_OFS_SW1_SEL    = 8'h23;
   localparam logic [7:0]  RSQ_OFS_SW1_DLY    = 8'h24;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0]  RSQ_RST_LDO3_DLY   = 8'h00;
   localparam logic [7:0]  RSQ_RST_SW1_MASK_A = 8'h00;
   localparam logic [7:0]  RSQ_RST_SW1_SEL    = 8'h80;
   localparam logic [7:0]  RSQ_RST_SW1_DLY    = 8'h00;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int          RSQ_BIT_COMBINE    = 7;
   localparam int          RSQ_BIT_SWAP       = 6;
   localparam int          RSQ_FALL_LSB       = 3;        // Falling delay, bits 5:3
   localparam int          RSQ_RISE_LSB       = 0;        // Rising delay, bits 2:0
   localparam int          RSQ_GOOD_LSB       = 5;        // Good level, bits 6:5
   localparam int          RSQ_SRC_LSB        = 2;        // Source select, bits 4:2
   localparam int          RSQ_MASK_SHARED    = 1;
   localparam int          RSQ_MASK_LDO3      = 0;

   // ==========================================================================
   // Source select codes
   // ==========================================================================
   localparam logic [2:0]  RSQ_SRC_IN1   = 3'h0;
   localparam logic [2:0]  RSQ_SRC_IN2   = 3'h1;
   localparam logic [2:0]  RSQ_SRC_IN5   = 3'h2;
   localparam logic [2:0]  RSQ_SRC_IN4   = 3'h3;
   localparam logic [2:0]  RSQ_SRC_IN3   = 3'h4;
   localparam logic [2:0]  RSQ_SRC_IN34  = 3'h5;
   localparam logic [2:0]  RSQ_SRC_IN6   = 3'h6;
   localparam logic [2:0]  RSQ_SRC_ONE   = 3'h7;

   // Delay code to nominal milliseconds
   function automatic logic [RSQ_MS_W-1:0] rsq_code_ms(input logic [2:0] code);
      unique case (code)
         3'h0: rsq_code_ms = 7'h00;
         3'h1: rsq_code_ms = 7'h02;
         3'h2: rsq_code_ms = 7'h04;
         3'h3: rsq_code_ms = 7'h08;
         3'h4: rsq_code_ms = 7'h10;
         3'h5: rsq_code_ms = 7'h18;
         3'h6: rsq_code_ms = 7'h20;
         3'h7: rsq_code_ms = 7'h40;
      endcase
   endfunction : rsq_code_ms

endpackage : rsq_pkg

// [rsq_edge_delay.sv]
// Edge delay unit: passes a level through after a programmed rise or fall
// delay in whole milliseconds. Assumes its input is already synchronous.
`timescale 1ns/100ps
module rsq_edge_delay
   import rsq_pkg::*;
#(
   parameter int CYC_PER_MS = RSQ_CYC_PER_MS
)(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       src_in,
   input  wire logic [2:0] rise_code,
   input  wire logic [2:0] fall_code,
   output logic            dly_out
);

   // ==========================================================================
   // Checks and state
   // ==========================================================================
   if (CYC_PER_MS < 1) begin : g_bad_rate
      $error("rsq_edge_delay: CYC_PER_MS must be at least 1");
   end

   localparam int SUB_W = $clog2(CYC_PER_MS + 1);
   localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(CYC_PER_MS - 1);

   logic                out_q,   out_d;
   logic [SUB_W-1:0]    sub_q,   sub_d;
   logic [RSQ_MS_W-1:0] ms_q,    ms_d;
   logic [RSQ_MS_W-1:0] target;

   assign target  = src_in ? rsq_code_ms(rise_code) : rsq_code_ms(fall_code);
   assign dly_out = out_q;

   // ==========================================================================
   // Timer: restarts whenever the input returns to the output level
   // ==========================================================================
   // Nominal count is exact; one extra cycle of latency is far inside tolerance
   always_comb begin
      out_d = out_q;
      sub_d = '0;
      ms_d  = '0;
      if (src_in != out_q) begin
         if (target == '0 || ms_q >= target) begin       // Code cut mid-count ends wait
            out_d = src_in;                              // R12
         end else if (sub_q == SUB_LAST) begin
            ms_d  = ms_q + 7'h01;                        // R5
         end else begin
            sub_d = sub_q + SUB_W'(1);
            ms_d  = ms_q;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         out_q <= 1'b0;
         sub_q <= '0;
         ms_q  <= '0;
      end else begin
         out_q <= out_d;
         sub_q <= sub_d;
         ms_q  <= ms_d;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_zero_delay_follow: assert property (@(posedge mclk) disable iff (sys_rst) // R4
      (src_in && !out_q && rise_code == 3'h0) |=> out_q)
      else $error("zero rise delay did not follow input");

   a_no_early_flip: assert property (@(posedge mclk) disable iff (sys_rst) // R13
      (src_in != out_q && target != '0 && ms_q < target) |=> out_q == $past(out_q))
      else $error("output changed before its delay ran out");

   a_glitch_restarts: assert property (@(posedge mclk) disable iff (sys_rst) // R13
      (src_in == out_q) |=> (ms_q == '0 && sub_q == '0))
      else $error("delay timer not restarted");

endmodule : rsq_edge_delay

// [rsq_rail_seq.sv]
// Rail enable sequencing for the first load switch and the third LDO rail,
// plus the combine and swap routing of the second switch and first LDO.
// Assumes control pins and power-good levels are asynchronous, and that the
// enable logic of the second switch and first LDO arrives on mclk.
//
// Contract
// R1: Combine bit drives switch two from switch one
// R2: Swap bit exchanges LDO one and switch two
// R3: LDO three falling delay coded in bits 5:3
// R4: LDO three rising delay coded in bits 2:0
// R5: Delays nominal, ten percent tolerance accepted
// R6: Mask A bits drop rail power-good when set
// R7: Mask B bits drop shared and LDO three
// R8: Source select chooses control input pins
// R9: Code 111 feeds constant one
// R10: Good level select 1.5/1.8/2.5/3.3 V
// R11: Switch one rise and fall delays
// R12: Enable needs delayed source and unmasked power-good
// R13: Delay counter restarts on source edges
`timescale 1ns/100ps
module rsq_rail_seq
   import rsq_pkg::*;
#(
   parameter int CYC_PER_MS = RSQ_CYC_PER_MS
)(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [5:0] control_input_pins,
   input  wire logic [5:0] power_good_stepdown,
   input  wire logic       power_good_switch_rail_a,
   input  wire logic       power_good_ldo_two,
   input  wire logic       power_good_shared_rail,
   input  wire logic       power_good_ldo_three,
   input  wire logic       ldo_three_req,
   input  wire logic       switch_two_logic_en,
   input  wire logic       ldo_one_logic_en,
   output logic            load_switch_one_en,
   output logic            load_switch_two_en,
   output logic            adjustable_ldo_one_en,
   output logic            adjustable_ldo_three_en,
   output logic      [1:0] switch_one_goodlevel_select
);

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   logic [7:0] ldo3_q,  ldo3_d;
   logic [7:0] mska_q,  mska_d;
   logic [7:0] sel_q,   sel_d;
   logic [7:0] dly_q,   dly_d;
   logic [7:0] rdata_q, rdata_d;

   // Reserved bits are kept as plain storage so software reads back its writes
   always_comb begin
      ldo3_d = ldo3_q;
      mska_d = mska_q;
      sel_d  = sel_q;
      dly_d  = dly_q;
      if (reg_wr) begin
         unique case (reg_addr)
            RSQ_OFS_LDO3_DLY:   ldo3_d = reg_wdata;
            RSQ_OFS_SW1_MASK_A: mska_d = reg_wdata;
            RSQ_OFS_SW1_SEL:    sel_d  = reg_wdata;
            RSQ_OFS_SW1_DLY:    dly_d  = reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data is registered; unmapped offsets read as zero
   always_comb begin
      unique case (reg_addr)
         RSQ_OFS_LDO3_DLY:   rdata_d = ldo3_q;
         RSQ_OFS_SW1_MASK_A: rdata_d = mska_q;
         RSQ_OFS_SW1_SEL:    rdata_d = sel_q;
         RSQ_OFS_SW1_DLY:    rdata_d = dly_q;
         default:            rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ldo3_q  <= RSQ_RST_LDO3_DLY;
         mska_q  <= RSQ_RST_SW1_MASK_A;
         sel_q   <= RSQ_RST_SW1_SEL;
         dly_q   <= RSQ_RST_SW1_DLY;
         rdata_q <= 8'h00;
      end else begin
         ldo3_q  <= ldo3_d;
         mska_q  <= mska_d;
         sel_q   <= sel_d;
         dly_q   <= dly_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Field views
   logic       combine_switch_enables;
   logic       swap_ldo_one_switch_two;
   logic [2:0] ldo_three_fall_delay;
   logic [2:0] ldo_three_rise_delay;
   logic [2:0] switch_one_fall_delay;
   logic [2:0] switch_one_rise_delay;
   logic [2:0] switch_one_source_select;

   assign combine_switch_enables   = ldo3_q[RSQ_BIT_COMBINE];
   assign swap_ldo_one_switch_two  = ldo3_q[RSQ_BIT_SWAP];
   assign ldo_three_fall_delay     = ldo3_q[RSQ_FALL_LSB +: 3];    // R3
   assign ldo_three_rise_delay     = ldo3_q[RSQ_RISE_LSB +: 3];    // R4
   assign switch_one_fall_delay    = dly_q[RSQ_FALL_LSB +: 3];     // R11
   assign switch_one_rise_delay    = dly_q[RSQ_RISE_LSB +: 3];     // R11
   assign switch_one_source_select = sel_q[RSQ_SRC_LSB +: 3];

   // Threshold code goes straight to the analog comparator
   assign switch_one_goodlevel_select = sel_q[RSQ_GOOD_LSB +: 2];  // R10

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   localparam int IN_W = 16;

   logic [IN_W-1:0] in_raw;
   logic [IN_W-1:0] meta_q;
   logic [IN_W-1:0] sync_q;

   assign in_raw = {control_input_pins, power_good_ldo_two, power_good_switch_rail_a,
                    power_good_stepdown, power_good_shared_rail, power_good_ldo_three};

   // Two stages; only the second stage feeds any logic
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= in_raw;
         sync_q <= meta_q;
      end
   end

   logic [5:0] ctl_s;
   logic [7:0] pg_a_s;
   logic [1:0] pg_b_s;

   assign ctl_s  = sync_q[15:10];
   assign pg_a_s = sync_q[9:2];
   assign pg_b_s = sync_q[1:0];

   // ==========================================================================
   // Source select and power-good gating for switch one
   // ==========================================================================
   logic sw1_src;
   logic sw1_pg_ok;

   // Bit k of the pin vector is control input k+1
   always_comb begin
      unique case (switch_one_source_select)
         RSQ_SRC_IN1:  sw1_src = ctl_s[0];                 // R8
         RSQ_SRC_IN2:  sw1_src = ctl_s[1];                 // R8
         RSQ_SRC_IN5:  sw1_src = ctl_s[4];                 // R8
         RSQ_SRC_IN4:  sw1_src = ctl_s[3];                 // R8
         RSQ_SRC_IN3:  sw1_src = ctl_s[2];                 // R8
         RSQ_SRC_IN34: sw1_src = ctl_s[2] & ctl_s[3];      // R8
         RSQ_SRC_IN6:  sw1_src = ctl_s[5];                 // R8
         RSQ_SRC_ONE:  sw1_src = 1'b1;                     // R9
      endcase
   end

   // A set mask bit forces that rail's term true
   assign sw1_pg_ok = &(pg_a_s | mska_q)                                   // R6
                    & (pg_b_s[RSQ_MASK_SHARED] | sel_q[RSQ_MASK_SHARED])   // R7
                    & (pg_b_s[RSQ_MASK_LDO3]   | sel_q[RSQ_MASK_LDO3]);    // R7

   // ==========================================================================
   // Edge delays
   // ==========================================================================
   logic sw1_dly;
   logic ldo3_dly;

   rsq_edge_delay #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_sw1_delay (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .src_in    (sw1_src),
      .rise_code (switch_one_rise_delay),
      .fall_code (switch_one_fall_delay),
      .dly_out   (sw1_dly)
   );

   rsq_edge_delay #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_ldo3_delay (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .src_in    (ldo_three_req),
      .rise_code (ldo_three_rise_delay),
      .fall_code (ldo_three_fall_delay),
      .dly_out   (ldo3_dly)
   );

   // ==========================================================================
   // Rail enables with combine and swap routing
   // ==========================================================================
   logic sw1_en_q,  sw1_en_d;
   logic sw2_en_q,  sw2_en_d;
   logic ldo1_en_q, ldo1_en_d;
   logic ldo3_en_q, ldo3_en_d;

   // Combine has priority over swap for switch two
   always_comb begin
      sw1_en_d  = sw1_dly & sw1_pg_ok;                     // R12
      ldo3_en_d = ldo3_dly;                                // R3
      if (combine_switch_enables) begin
         sw2_en_d = sw1_en_d;                              // R1
      end else if (swap_ldo_one_switch_two) begin
         sw2_en_d = ldo_one_logic_en;                      // R2
      end else begin
         sw2_en_d = switch_two_logic_en;
      end
      ldo1_en_d = swap_ldo_one_switch_two ? switch_two_logic_en : ldo_one_logic_en; // R2
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sw1_en_q  <= 1'b0;
         sw2_en_q  <= 1'b0;
         ldo1_en_q <= 1'b0;
         ldo3_en_q <= 1'b0;
      end else begin
         sw1_en_q  <= sw1_en_d;
         sw2_en_q  <= sw2_en_d;
         ldo1_en_q <= ldo1_en_d;
         ldo3_en_q <= ldo3_en_d;
      end
   end

   assign load_switch_one_en      = sw1_en_q;
   assign load_switch_two_en      = sw2_en_q;
   assign adjustable_ldo_one_en   = ldo1_en_q;
   assign adjustable_ldo_three_en = ldo3_en_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_const_one_src: assert property (@(posedge mclk) disable iff (sys_rst) // R9
      (switch_one_source_select == RSQ_SRC_ONE) |-> sw1_src)
      else $error("select 111 did not give constant one");

   a_pair_src: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (switch_one_source_select == RSQ_SRC_IN34) |-> (sw1_src == (ctl_s[2] & ctl_s[3])))
      else $error("select 101 did not join inputs three and four");

   a_pin_to_src: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (switch_one_source_select == RSQ_SRC_IN5) |-> (sw1_src == ctl_s[4]))
      else $error("select 010 did not pick input five");

   a_pg_gate_off: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      (!sw1_pg_ok) |=> !load_switch_one_en)
      else $error("switch one on without power-good");

   a_mask_b_gate: assert property (@(posedge mclk) disable iff (sys_rst) // R7
      (!pg_b_s[RSQ_MASK_LDO3] && !sel_q[RSQ_MASK_LDO3]) |=> !load_switch_one_en)
      else $error("unmasked LDO three power-good ignored");

   a_mask_a_gate: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      (|(~pg_a_s & ~mska_q)) |=> !load_switch_one_en)
      else $error("unmasked rail power-good ignored");

   a_shared_gate: assert property (@(posedge mclk) disable iff (sys_rst) // R7
      (!pg_b_s[RSQ_MASK_SHARED] && !sel_q[RSQ_MASK_SHARED]) |=> !load_switch_one_en)
      else $error("unmasked shared power-good ignored");

   a_combine_follow: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      combine_switch_enables |=> (load_switch_two_en == load_switch_one_en))
      else $error("combined switch two differs from switch one");

   a_swap_route: assert property (@(posedge mclk) disable iff (sys_rst) // R2
      swap_ldo_one_switch_two |=> (adjustable_ldo_one_en == $past(switch_two_logic_en)))
      else $error("swap did not route switch two logic to LDO one");

   a_swap_sw2: assert property (@(posedge mclk) disable iff (sys_rst) // R2
      (swap_ldo_one_switch_two && !combine_switch_enables)
         |=> (load_switch_two_en == $past(ldo_one_logic_en)))
      else $error("swap did not route LDO one logic to switch two");

   a_plain_route: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      (!swap_ldo_one_switch_two && !combine_switch_enables)
         |=> (load_switch_two_en == $past(switch_two_logic_en)
              && adjustable_ldo_one_en == $past(ldo_one_logic_en)))
      else $error("unswapped rails did not follow their own logic");

   a_dly_write: assert property (@(posedge mclk) disable iff (sys_rst) // R11
      (reg_wr && reg_addr == RSQ_OFS_SW1_DLY)
         |=> (switch_one_rise_delay == $past(reg_wdata[2:0])))
      else $error("rise delay field not written");

   a_rise_wait: assert property (@(posedge mclk) disable iff (sys_rst) // R12
      $rose(load_switch_one_en) |-> $past(sw1_dly) && $past(sw1_pg_ok))
      else $error("switch one rose without delayed source and power-good");

endmodule : rsq_rail_seq

// [rsq_host_model.sv]
// Host-side model of the processor that drives the six control input pins.
// Assumes the bench asks for pin levels; a released host leaves the pins pulled low.
`timescale 1ns/100ps
module rsq_host_model (
   input  wire logic       host_drive,
   input  wire logic [5:0] pin_req,
   output logic      [5:0] control_input_pins
);
   // ==========================================================================
   // Pin drive
   // ==========================================================================
   // Board pull-downs drop switch one on any pin source while the host is not driving
   assign control_input_pins = host_drive ? pin_req : 6'h00;
endmodule : rsq_host_model

// [tb_rail_enable_sequencing_logic.sv]
// Self-checking bench for the rail enable sequencing block.
// Assumes the design package and a shortened millisecond of CPM cycles.
`timescale 1ns/100ps
module tb_rail_enable_sequencing_logic;
   import rsq_pkg::*;
   // ==========================================================================
   // Signals and instances
   // ==========================================================================
   localparam int CPM = 10;
   logic       mclk, sys_rst, reg_wr, host_drive, ldo_three_req, sw2_in, ldo1_in;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [5:0] pin_req, pins;
   logic [9:0] pg;
   logic       sw1_en, sw2_en, ldo1_en, ldo3_en;
   logic [1:0] good_sel;
   int         num_errors, checks_done, cyc, c, k, j, i;
   int         ms_tab [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
   logic [5:0] src_tab [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};

   rsq_host_model u_rsq_host_model (.host_drive(host_drive), .pin_req(pin_req),
      .control_input_pins(pins));

   rsq_rail_seq #(.CYC_PER_MS(CPM)) u_rsq_rail_seq (
      .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .control_input_pins(pins),
      .power_good_stepdown(pg[5:0]), .power_good_switch_rail_a(pg[6]),
      .power_good_ldo_two(pg[7]), .power_good_shared_rail(pg[9]),
      .power_good_ldo_three(pg[8]), .ldo_three_req(ldo_three_req),
      .switch_two_logic_en(sw2_in), .ldo_one_logic_en(ldo1_in),
      .load_switch_one_en(sw1_en), .load_switch_two_en(sw2_en),
      .adjustable_ldo_one_en(ldo1_en), .adjustable_ldo_three_en(ldo3_en),
      .switch_one_goodlevel_select(good_sel));

   // Clock and a hang guard sized well above the longest delay sweep
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : chk

   // One-cycle write strobe, launched off the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   // Read data lags the address by one edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      chk("reg_rdata", exp, reg_rdata);
   endtask : rd

   task automatic settle();
      repeat (8) @(negedge mclk);
   endtask : settle

   // Counts cycles until the chosen enable reaches lvl; nominal ms allows 10 percent
   task automatic meas(input logic is_ldo, input logic lvl, input int ms);
      int n;
      n = 0;
      while ((is_ldo ? ldo3_en : sw1_en) !== lvl && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      checks_done++;
      if (n * 100 < ms * CPM * (100 - RSQ_TOL_PCT) ||
          n * 100 > ms * CPM * (100 + RSQ_TOL_PCT) + 600) begin
         $display("unexpected delay cycles expected %0d seen %0d", ms * CPM, n);
         num_errors++;
      end
   endtask : meas

   task automatic tally_and_finish();
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      mclk = 0; sys_rst = 1; reg_wr = 0; reg_addr = 0; reg_wdata = 0;
      host_drive = 1; pin_req = 0; pg = 10'h3ff; ldo_three_req = 0;
      sw2_in = 0; ldo1_in = 0; num_errors = 0; checks_done = 0; cyc = 0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 0;
      // Reset values, full read-write access, unmapped offset ignored
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h80);
      rd(8'h24, 8'h00);
      wr(8'h30, 8'h5a);
      rd(8'h30, 8'h00);
      for (c = 8'h21; c < 8'h25; c++) begin
         wr(8'(c), 8'(c) ^ 8'ha5);
         rd(8'(c), 8'(c) ^ 8'ha5);
      end
      wr(8'h21, 8'h00);
      wr(8'h24, 8'h00);
      wr(8'h22, 8'h00);
      // Every source code with the selected pin, none and the others
      for (c = 0; c < 8; c++) begin
         wr(8'h23, 8'(c * 4));
         pin_req = 6'h00;
         settle();
         chk("sw1 idle", 8'(c == 7), 8'(sw1_en));
         pin_req = src_tab[c];
         settle();
         chk("sw1 selected", 8'h01, 8'(sw1_en));
         pin_req = (c == 5) ? 6'h37 : ~src_tab[c];
         settle();
         chk("sw1 other", 8'(c == 7), 8'(sw1_en));
      end
      // Each power-good drops the rail, and its mask bit restores it
      for (i = 0; i < 10; i++) begin
         pg = 10'h3ff ^ (10'h001 << i);
         settle();
         chk("sw1 pg low", 8'h00, 8'(sw1_en));
         if (i < 8) wr(8'h22, 8'h01 << i);
         else wr(8'h23, 8'h1c | (8'h01 << (i - 8)));
         settle();
         chk("sw1 pg masked", 8'h01, 8'(sw1_en));
         wr(8'h22, 8'h00);
         wr(8'h23, 8'h1c);
      end
      pg = 10'h3ff;
      for (c = 0; c < 4; c++) begin
         wr(8'h23, 8'(c * 32 + 8'h1c));
         settle();
         chk("goodlevel", 8'(c), 8'(good_sel));
      end
      // Edge delays for every nonzero code, rise and fall codes differing except code 4 on both
      wr(8'h23, 8'h00);
      pin_req = 6'h00;
      settle();
      for (c = 1; c < 8; c++) begin
         wr(8'h24, 8'((8 - c) * 8 + c));
         pin_req = 6'h01;
         meas(1'b0, 1'b1, ms_tab[c]);
         pin_req = 6'h00;
         meas(1'b0, 1'b0, ms_tab[8 - c]);
         wr(8'h21, 8'((8 - c) * 8 + c));
         ldo_three_req = 1'b1;
         meas(1'b1, 1'b1, ms_tab[c]);
         ldo_three_req = 1'b0;
         meas(1'b1, 1'b0, ms_tab[8 - c]);
      end
      // Pulses shorter than the delay leave the rail where it was
      wr(8'h21, 8'h00);
      wr(8'h24, 8'h09);
      pin_req = 6'h01;
      repeat (5) @(negedge mclk);
      pin_req = 6'h00;
      repeat (40) @(negedge mclk);
      chk("sw1 short high", 8'h00, 8'(sw1_en));
      pin_req = 6'h01;
      meas(1'b0, 1'b1, 2);
      pin_req = 6'h00;
      repeat (5) @(negedge mclk);
      pin_req = 6'h01;
      repeat (40) @(negedge mclk);
      chk("sw1 short low", 8'h01, 8'(sw1_en));
      // A released host leaves the pins at their pull-down level
      host_drive = 1'b0;
      meas(1'b0, 1'b0, 2);
      // Combine and swap routing with switch one both off and on
      wr(8'h24, 8'h00);
      pin_req = 6'h00;
      host_drive = 1'b1;
      ldo1_in = 1'b1;
      for (j = 0; j < 2; j++) begin
         wr(8'h23, j ? 8'h1c : 8'h00);
         for (k = 0; k < 4; k++) begin
            wr(8'h21, 8'(k * 64));
            settle();
            chk("sw2 en", (k >= 2) ? 8'(j) : 8'(k), 8'(sw2_en));
            chk("ldo1 en", 8'(1 - k % 2), 8'(ldo1_en));
         end
      end
      tally_and_finish();
   end
endmodule : tb_rail_enable_sequencing_logic
